/* File: core/odts_defines.vh */
// Constants for the on-die termination selector: register map, field
// positions, termination state codes and latency arithmetic.
// Assumes inclusion by bare name from the design files under core/.
`ifndef ODTS_DEFINES_VH
`define ODTS_DEFINES_VH

`define ODTS_REG_NOM 12'h000
`define ODTS_REG_WR 12'h004
`define ODTS_REG_PARK 12'h008
`define ODTS_REG_CTRL 12'h00c
`define ODTS_REG_LAT 12'h010
`define ODTS_REG_STAT 12'h014

`define ODTS_NOM_RST 3'h0
`define ODTS_WR_RST 3'h0
`define ODTS_PARK_RST 3'h0
`define ODTS_WR_MASK 3'h3

`define ODTS_CTRL_SREF 0
`define ODTS_CTRL_PRE2 1
`define ODTS_LAT_WL_LSB 0
`define ODTS_LAT_RL_LSB 8
`define ODTS_LAT_BL_LSB 16
`define ODTS_WL_RST 8'h09
`define ODTS_RL_RST 8'h0b
`define ODTS_BL_RST 8'h08

`define ODTS_X_PRE1 8'h02
`define ODTS_X_PRE2 8'h03
`define ODTS_WR_HOLD 8'h06
`define ODTS_DLY_DEPTH 64

`define ODTS_ST_HIZ 4'h1
`define ODTS_ST_PARK 4'h2
`define ODTS_ST_NOM 4'h4
`define ODTS_ST_WR 4'h8

`endif

/* File: core/odts_delay_line.v */
// Programmable delay line for one bit: output equals input from
// delay cycles ago (delay 0 passes through).
// Assumes a single clock domain and delay below the depth.
`timescale 1ns/1ns
`default_nettype none
`include "odts_defines.vh"
module odts_delay_line (
  input wire core_clk,
  input wire reset_n,
  input wire din,
  input wire [7:0] delay,
  output wire dout
);
  reg [`ODTS_DLY_DEPTH-1:0] pipe_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pipe_q <= {`ODTS_DLY_DEPTH{1'b0}};
    end else begin
      pipe_q <= {pipe_q[`ODTS_DLY_DEPTH-2:0], din};
    end
  end
  assign dout = (delay == 8'h00) ? din :
    pipe_q[delay[5:0] - 6'h01];
endmodule
`default_nettype wire

/* File: core/odts_top.v */
// On-die termination selector with AHB-Lite register port.
// Assumes ODT pin is asynchronous, command strobes are core_clk pulses.
`timescale 1ns/1ns
`default_nettype none
`include "odts_defines.vh"
module odts_top (
  input wire core_clk,
  input wire reset_n,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire odt_pin,
  input wire wr_cmd,
  input wire rd_cmd,
  output reg [3:0] term_state,
  output reg [2:0] term_code,
  output reg [21:0] term_en_x16,
  output reg odt_rx_en
);
  reg [2:0] nom_q;
  reg [2:0] wr_q;
  reg [2:0] park_q;
  reg sref_q;
  reg pre2_q;
  reg [7:0] wl_q;
  reg [7:0] rl_q;
  reg [7:0] bl_q;
  reg odt_s1_q;
  reg odt_s2_q;
  reg [7:0] rd_cnt_q;
  reg [7:0] wr_cnt_q;
  reg [11:0] addr_q;
  reg wen_q;
  reg ren_q;
  wire [7:0] x_val;
  wire [7:0] odt_lat;
  wire [7:0] rd_lat;
  wire nom_on;
  wire wr_on;
  wire park_on;
  wire odt_gated;
  wire odt_late;
  wire wr_late;
  wire rd_late;
  wire any_en;
  wire acc;
  reg [3:0] state_d;
  reg [2:0] code_d;

  // Bus decode; zero wait states, always OKAY.
  assign acc = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 12'h000;
      wen_q <= 1'b0;
      ren_q <= 1'b0;
    end else begin
      addr_q <= haddr;
      wen_q <= acc & hwrite;
      ren_q <= acc & ~hwrite;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nom_q <= `ODTS_NOM_RST;
      wr_q <= `ODTS_WR_RST;
      park_q <= `ODTS_PARK_RST;
      sref_q <= 1'b0;
      pre2_q <= 1'b0;
      wl_q <= `ODTS_WL_RST;
      rl_q <= `ODTS_RL_RST;
      bl_q <= `ODTS_BL_RST;
    end else if (wen_q) begin
      case (addr_q)
        `ODTS_REG_NOM: nom_q <= hwdata[2:0];
        `ODTS_REG_WR: wr_q <= hwdata[2:0] & `ODTS_WR_MASK;
        `ODTS_REG_PARK: park_q <= hwdata[2:0];
        `ODTS_REG_CTRL: begin
          sref_q <= hwdata[`ODTS_CTRL_SREF];
          pre2_q <= hwdata[`ODTS_CTRL_PRE2];
        end
        `ODTS_REG_LAT: begin
          wl_q <= hwdata[`ODTS_LAT_WL_LSB+7:`ODTS_LAT_WL_LSB];
          rl_q <= hwdata[`ODTS_LAT_RL_LSB+7:`ODTS_LAT_RL_LSB];
          bl_q <= hwdata[`ODTS_LAT_BL_LSB+7:`ODTS_LAT_BL_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (acc & ~hwrite) begin
      case (haddr)
        `ODTS_REG_NOM: hrdata <= {29'h0, nom_q};
        `ODTS_REG_WR: hrdata <= {29'h0, wr_q};
        `ODTS_REG_PARK: hrdata <= {29'h0, park_q};
        `ODTS_REG_CTRL: hrdata <= {30'h0, pre2_q, sref_q};
        `ODTS_REG_LAT: hrdata <= {8'h00, bl_q, rl_q, wl_q};
        `ODTS_REG_STAT: hrdata <= {23'h0, odt_rx_en, any_en,
          term_code, term_state};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ODT pin synchroniser.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      odt_s1_q <= 1'b0;
      odt_s2_q <= 1'b0;
    end else begin
      odt_s1_q <= odt_pin;
      odt_s2_q <= odt_s1_q;
    end
  end

  assign any_en = (nom_q != 3'h0) | (wr_q != 3'h0) | (park_q != 3'h0);
  assign x_val = pre2_q ? `ODTS_X_PRE2 : `ODTS_X_PRE1;
  assign odt_lat = wl_q - x_val;
  assign rd_lat = rl_q - x_val;
  assign odt_gated = odt_s2_q & (nom_q != 3'h0) & ~sref_q;

  odts_delay_line u_odt_dly (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(odt_gated),
    .delay(odt_lat),
    .dout(odt_late)
  );

  odts_delay_line u_wr_dly (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(wr_cmd & (wr_q != 3'h0)),
    .delay(odt_lat),
    .dout(wr_late)
  );

  odts_delay_line u_rd_dly (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(rd_cmd),
    .delay(rd_lat),
    .dout(rd_late)
  );

  // Window counters for read disable and write termination.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_cnt_q <= 8'h00;
      wr_cnt_q <= 8'h00;
    end else if (sref_q) begin
      rd_cnt_q <= 8'h00;
      wr_cnt_q <= 8'h00;
    end else begin
      if (rd_late) begin
        rd_cnt_q <= (bl_q >> 1) + x_val - 8'h01;
      end else if (rd_cnt_q != 8'h00) begin
        rd_cnt_q <= rd_cnt_q - 8'h01;
      end
      if (wr_late) begin
        wr_cnt_q <= `ODTS_WR_HOLD - 8'h01;
      end else if (wr_cnt_q != 8'h00) begin
        wr_cnt_q <= wr_cnt_q - 8'h01;
      end
    end
  end

  assign wr_on = wr_late | (wr_cnt_q != 8'h00);
  assign nom_on = odt_late & (nom_q != 3'h0);
  assign park_on = park_q != 3'h0;

  always @* begin
    state_d = `ODTS_ST_HIZ;
    code_d = 3'h0;
    if (sref_q) begin
      state_d = `ODTS_ST_HIZ;
    end else if (rd_late | (rd_cnt_q != 8'h00)) begin
      state_d = `ODTS_ST_HIZ;
    end else if (wr_on) begin
      state_d = `ODTS_ST_WR;
      code_d = wr_q;
    end else if (nom_on) begin
      state_d = `ODTS_ST_NOM;
      code_d = nom_q;
    end else if (park_on) begin
      state_d = `ODTS_ST_PARK;
      code_d = park_q;
    end
  end

  // Registered one-hot state, updated every rising edge.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      term_state <= `ODTS_ST_HIZ;
      term_code <= 3'h0;
      term_en_x16 <= 22'h000000;
      odt_rx_en <= 1'b0;
    end else begin
      term_state <= state_d;
      term_code <= code_d;
      term_en_x16 <= {22{code_d != 3'h0}};
      odt_rx_en <= (nom_q != 3'h0) & ~sref_q;
    end
  end
endmodule
`default_nettype wire

/* File: verification/odts_ctrl_model.sv */
// Memory controller model driving the ODT pin and command strobes.
// Assumes changes are launched just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module odts_ctrl_model (
  input wire logic core_clk,
  output logic odt_pin,
  output logic wr_cmd,
  output logic rd_cmd
);
  initial begin
    odt_pin = 1'b0;
    wr_cmd = 1'b0;
    rd_cmd = 1'b0;
  end
  task automatic set_odt(input logic v);
    @(posedge core_clk);
    odt_pin <= v;
  endtask
  task automatic pulse(input logic w);
    @(posedge core_clk);
    wr_cmd <= w;
    rd_cmd <= ~w;
    @(posedge core_clk);
    wr_cmd <= 1'b0;
    rd_cmd <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/odts_properties.sv */
// Port checker for odts_top, bound to every instance.
// Assumes default latencies and one-cycle command pulses.
`timescale 1ns/1ns
`default_nettype none
module odts_props (
  input wire core_clk,
  input wire reset_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire wr_cmd,
  input wire rd_cmd,
  input wire [3:0] term_state,
  input wire [2:0] term_code,
  input wire [21:0] term_en_x16,
  input wire odt_rx_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic rd_tk;
  logic [5:0] since_wr_q;
  assign rd_tk = hsel & hready & htrans[1] & ~hwrite;
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n) since_wr_q <= 6'h3f;
    else if (wr_cmd) since_wr_q <= 6'h00;
    else if (since_wr_q != 6'h3f) since_wr_q <= since_wr_q + 6'h01;
  sequence s_rd;
    rd_cmd;
  endsequence
  sequence s_hiz;
    term_state == 4'h1 ##1 term_state == 4'h1;
  endsequence
  a_state_onehot: assert property ($onehot(term_state))
    else $error("State not one-hot.");
  a_hiz_quiet: assert property (term_state == 4'h1 |->
    term_code == 3'h0 && term_en_x16 == 22'h0) else $error("HiZ leaks.");
  a_en_all: assert property (term_state != 4'h1 |-> &term_en_x16)
    else $error("Partial pin enable.");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("Bus not ready or not okay.");
  a_rd_hiz: assert property (s_rd |-> ##[9:11] s_hiz)
    else $error("Read did not free the bus.");
  a_nom_rx: assert property (!odt_rx_en [*2] |-> term_state != 4'h4)
    else $error("Nominal with receiver off.");
  a_wr_window: assert property (term_state == 4'h8 |->
    since_wr_q >= 6'h06 && since_wr_q <= 6'h10) else $error("Stray write.");
  a_rdata_hold: assert property (!$past(rd_tk) |-> $stable(hrdata))
    else $error("Read data moved.");
endmodule
bind odts_top odts_props chk_u (.core_clk(core_clk), .reset_n(reset_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wr_cmd(wr_cmd),
  .rd_cmd(rd_cmd), .term_state(term_state), .term_code(term_code),
  .term_en_x16(term_en_x16), .odt_rx_en(odt_rx_en));
`default_nettype wire

/* File: verification/odts_top_tb.sv */
// Self-checking bench for odts_top with a controller model.
// Assumes the default latency register: WL 9, RL 11, BL 8.
`timescale 1ns/1ns
`default_nettype none
`include "odts_defines.vh"
module odts_top_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, odt_pin, wr_cmd, rd_cmd, odt_rx_en;
  wire [3:0] term_state;
  wire [2:0] term_code;
  wire [21:0] term_en_x16;
  int num_errors = 0;
  int n_checks = 0;
  int nom, park, wrf, sref, i;
  always #20 core_clk = ~core_clk;
  odts_ctrl_model ctl_u (.core_clk(core_clk), .odt_pin(odt_pin),
    .wr_cmd(wr_cmd), .rd_cmd(rd_cmd));
  odts_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .odt_pin(odt_pin),
    .wr_cmd(wr_cmd), .rd_cmd(rd_cmd), .term_state(term_state),
    .term_code(term_code), .term_en_x16(term_en_x16), .odt_rx_en(odt_rx_en));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input int d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Phase 0 idle, 1 inside a write window, 2 inside a read window.
  task automatic expect_term(input int odt, input int ph);
    int st;
    int cd;
    st = 1;
    cd = 0;
    if (sref == 0 && ph != 2) begin
      if (ph == 1 && wrf != 0) begin
        st = 8;
        cd = wrf;
      end else if (odt != 0 && nom != 0) begin
        st = 4;
        cd = nom;
      end else if (park != 0) begin
        st = 2;
        cd = park;
      end
    end
    chk("term_state", term_state, st);
    chk("term_code", term_code, cd);
    chk("term_en_x16", term_en_x16, st == 1 ? 0 : 32'h3fffff);
    chk("odt_rx_en", odt_rx_en, nom != 0 && sref == 0);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    i = $urandom(36358);
    {nom, park, wrf, sref} = '0;
    wt(10);
    reset_n <= 1'b1;
    bus(0, `ODTS_REG_LAT, 0);
    chk("lat", rd, 32'h00080b09);
    bus(0, `ODTS_REG_STAT, 0);
    chk("status", rd, 32'h1);
    expect_term(0, 0);
    for (i = 0; i < 3; i++) begin
      nom = (i == 1) ? 0 : $urandom_range(7, 1);
      park = (i == 2) ? 0 : $urandom_range(7, 1);
      wrf = (i == 2) ? 0 : $urandom_range(3, 1);
      bus(1, `ODTS_REG_NOM, nom);
      bus(1, `ODTS_REG_PARK, park);
      bus(1, `ODTS_REG_WR, wrf | 4);
      bus(0, `ODTS_REG_WR, 0);
      chk("wr field", rd, wrf);
      ctl_u.set_odt(1'b0);
      wt(15);
      expect_term(0, 0);
      ctl_u.set_odt(1'b1);
      wt(15);
      expect_term(1, 0);
      ctl_u.pulse(1'b1);
      wt(10);
      expect_term(1, 1);
      wt(12);
      expect_term(1, 0);
      ctl_u.pulse(1'b0);
      wt(12);
      expect_term(1, 2);
      wt(12);
    end
    bus(1, `ODTS_REG_CTRL, 2);
    bus(0, `ODTS_REG_CTRL, 0);
    chk("ctrl", rd, 32'h2);
    ctl_u.pulse(1'b0);
    wt(9);
    expect_term(1, 2);
    wt(12);
    expect_term(1, 0);
    bus(1, `ODTS_REG_CTRL, 1);
    sref = 1;
    wt(15);
    expect_term(1, 0);
    bus(0, `ODTS_REG_STAT, 0);
    chk("status", rd, (((nom | park | wrf) != 0) << 7) | 1);
    bus(0, 12'h100, 0);
    chk("unmapped", rd, 32'h0);
    complete_run;
  end
  initial begin
    wt(5000);
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
